// >>> hdl/dtc_counter.sv
// One 8-bit up-counter with synchronous clear and clear-on-match.
// Assumes tick, clear and matchClr are decided by the enclosing timer.
`timescale 1ns/1ps
module dtc_counter
    import dtc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic clear,
    input wire logic tick,
    input wire logic matchClr,
    output logic [7:0] count
);

    logic [7:0] count_q;

    // Counting wraps through zero on overflow, so overflow clears too.
    // step and clear
    always_ff @(posedge clk) begin
        if (srst || clear) begin
            count_q <= RST_BYTE;
        end else if (tick) begin
            count_q <= matchClr ? RST_BYTE : count_q + 8'h01;
        end
    end

    assign count = count_q;

endmodule : dtc_counter

// >>> hdl/dtc_prescaler.sv
// Binary prescaler: one pulse output per power of two of the input ticks.
// Assumes tickIn is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
module dtc_prescaler
    import dtc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic tickIn,
    output logic [WIDTH:0] tapOut
);

    logic [WIDTH-1:0] div_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            div_q <= '0;
        end else if (tickIn) begin
            div_q <= div_q + 1'b1;
        end
    end

    assign tapOut[0] = tickIn;

    for (genvar i = 1; i <= WIDTH; i++) begin : gTap
        assign tapOut[i] = tickIn && (&div_q[i-1:0]);
    end

endmodule : dtc_prescaler

// >>> hdl/dtc_top.sv
// Dual 8-bit timer: discrete, cascade, carrier generator and PWM modes.
// Assumes a synchronous 8-bit register port and a synchronous event pin.
//
// Contract
// - Timer A raises its interrupt when its count equals its compare, outside cascade and PWM modes.
// - Timer B raises its interrupt when its count equals its compare, outside cascade mode.
// - Cascade: B interrupt only on joint match; A interrupt never raised.
// - Cascade chains both counters into one 16-bit timer or event counter.
// - Discrete: both time; only B counts events and drives square wave.
// - Carrier mode emits B's carrier gated in periods set by timer A.
// - PWM mode emits duty set by timer B; timer A offers no PWM.
// - Carrier and PWM: high-width compare sets how long output stays high.
// - Both counts are read-only bytes, reset to zero.
// - Discrete: A clears on reset, enable clear, match and overflow.
// - Discrete: B clears on reset, enable clear, match and overflow.
// - Cascade: both clear on reset, B enable clear, or joint match.
// - Cascade: both clear together on joint overflow.
// - Carrier and PWM: B clears on reset, enable clear, match, overflow.
// - Outside cascade, writing zero to A enable clears counter A and halts it.
// - A mode register resets to zero; bits 6 and 0 read zero.
// - Mode decoded from both mode fields; other codes are prohibited.
// - Cascade: A enable ignored, B enable runs both, A counts B.
// - Carrier: next bit moves to active bit on each timer A match.
// - Timer A clock: /64, /256, B match or B output.
`timescale 1ns/1ps
module dtc_top
    import dtc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [15:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic eventClockInputPin,
    output logic timerOutputPin,
    output logic timerAMatchIrq,
    output logic timerBMatchIrq
);

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0] modeA_q;
    logic [7:0] modeB_q;
    logic [7:0] carrierCtl_q;
    logic [7:0] cmpA_q;
    logic [7:0] cmpB_q;
    logic [7:0] cmpBHigh_q;
    logic [7:0] rdData_q;
    logic [7:0] countA;
    logic [7:0] countB;

    always_ff @(posedge clk) begin
        if (srst) begin
            modeA_q <= RST_BYTE;
            modeB_q <= RST_BYTE;
            carrierCtl_q <= RST_BYTE;
            cmpA_q <= RST_BYTE;
            cmpB_q <= RST_BYTE;
            cmpBHigh_q <= RST_BYTE;
        end else if (regWrEn) begin
            case (regAddr)
                ADDR_A_MODE: modeA_q <= regWrData & MODE_A_MASK;
                ADDR_B_MODE: modeB_q <= regWrData & MODE_B_MASK;
                ADDR_CARRIER: carrierCtl_q <= regWrData & CARRIER_MASK;
                ADDR_A_CMP: cmpA_q <= regWrData;
                ADDR_B_CMP: cmpB_q <= regWrData;
                ADDR_B_HWCMP: cmpBHigh_q <= regWrData;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdData_q <= RST_BYTE;
        end else if (regRdEn) begin
            case (regAddr)
                ADDR_A_COUNT: rdData_q <= countA;
                ADDR_B_COUNT: rdData_q <= countB;
                ADDR_A_MODE: rdData_q <= modeA_q;
                ADDR_B_MODE: rdData_q <= modeB_q;
                ADDR_A_CMP: rdData_q <= cmpA_q;
                ADDR_B_CMP: rdData_q <= cmpB_q;
                ADDR_B_HWCMP: rdData_q <= cmpBHigh_q;
                default: rdData_q <= RST_BYTE;
            endcase
        end
    end

    assign regRdData = rdData_q;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode.

    dtc_mode_e mode;
    logic [3:0] modeCode;

    assign modeCode = {modeA_q[BIT_MODE_HI:BIT_MODE_LO],
                       modeB_q[BIT_MODE_HI:BIT_MODE_LO]};

    always_comb begin
        case (modeCode)
            MODE_DISCRETE: mode = DTC_DISCRETE;
            MODE_CASCADE: mode = DTC_CASCADE;
            MODE_CARRIER: mode = DTC_CARRIER;
            MODE_PWM: mode = DTC_PWM;
            default: mode = DTC_PROHIBITED;
        endcase
    end

    logic isCascade;
    logic isWave;
    logic enA;
    logic enB;

    assign isCascade = (mode == DTC_CASCADE);
    assign isWave = (mode == DTC_CARRIER) || (mode == DTC_PWM);
    assign enA = isCascade ? modeB_q[BIT_ENABLE] :
                 (modeA_q[BIT_ENABLE] && (mode != DTC_PROHIBITED));
    assign enB = modeB_q[BIT_ENABLE] && (mode != DTC_PROHIBITED);

    ////////////////////////////////////////////////////////////////////////
    // Count clocks.

    logic evPrev_q;
    logic evEdge;
    logic [SYS_DIV_BITS:0] sysTap;
    logic [EXT_DIV_BITS:0] extTap;

    always_ff @(posedge clk) begin
        if (srst) begin
            evPrev_q <= 1'b0;
        end else begin
            evPrev_q <= eventClockInputPin;
        end
    end

    assign evEdge = eventClockInputPin && !evPrev_q;

    dtc_prescaler #(.WIDTH(SYS_DIV_BITS)) uSysDiv (
        .clk(clk),
        .srst(srst),
        .tickIn(1'b1),
        .tapOut(sysTap)
    );

    dtc_prescaler #(.WIDTH(EXT_DIV_BITS)) uExtDiv (
        .clk(clk),
        .srst(srst),
        .tickIn(evEdge),
        .tapOut(extTap)
    );

    logic tickB;
    logic tickA;
    logic tickASel;
    logic bOut_q;
    logic bOutPrev_q;
    logic eventB;

    always_comb begin
        case (modeB_q[BIT_CLK_HI:BIT_CLK_LO])
            B_CLK_SYS: tickB = enB;
            B_CLK_DIV4: tickB = enB && sysTap[TAP_DIV4];
            B_CLK_EXT: tickB = enB && extTap[0];
            B_CLK_EXT2: tickB = enB && extTap[1];
            B_CLK_EXT4: tickB = enB && extTap[2];
            B_CLK_EXT8: tickB = enB && extTap[3];
            default: tickB = 1'b0;
        endcase
    end

    always_comb begin
        case (modeA_q[BIT_CLK_HI:BIT_CLK_LO])
            A_CLK_DIV64: tickASel = sysTap[TAP_DIV64];
            A_CLK_DIV256: tickASel = sysTap[TAP_DIV256];
            A_CLK_BMATCH: tickASel = eventB;
            A_CLK_BOUT: tickASel = bOut_q && !bOutPrev_q;
            default: tickASel = 1'b0;
        endcase
    end

    assign tickA = isCascade ? (tickB && countB == COUNT_MAX) :
                   (enA && tickASel);

    ////////////////////////////////////////////////////////////////////////
    // Compare and clear.

    logic eqA;
    logic eqB;
    logic highPhase_q;
    logic jointMatch;
    logic clrB;
    logic clrA;
    logic clearBoth;

    assign eqA = (countA == cmpA_q);
    assign eqB = (isWave && highPhase_q) ? (countB == cmpBHigh_q) :
                 (countB == cmpB_q);
    assign jointMatch = eqA && eqB;

    assign clrB = isCascade ? jointMatch : eqB;
    assign clrA = eqA && !isCascade;
    assign clearBoth = isCascade && tickB && jointMatch;
    assign eventB = tickB && clrB;

    dtc_counter uCountA (
        .clk(clk),
        .srst(srst),
        .clear(!enA || clearBoth),
        .tick(tickA),
        .matchClr(clrA),
        .count(countA)
    );

    dtc_counter uCountB (
        .clk(clk),
        .srst(srst),
        .clear(!enB),
        .tick(tickB),
        .matchClr(clrB),
        .count(countB)
    );

    ////////////////////////////////////////////////////////////////////////
    // Output generation.

    logic activeBit_q;
    logic outLevel;

    always_ff @(posedge clk) begin
        if (srst || !enB || !isWave) begin
            highPhase_q <= 1'b0;
        end else if (eventB) begin
            highPhase_q <= !highPhase_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !enB) begin
            bOut_q <= 1'b0;
        end else if (isWave) begin
            bOut_q <= eventB ? !highPhase_q : highPhase_q;
        end else if (eventB) begin
            bOut_q <= !bOut_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bOutPrev_q <= 1'b0;
        end else begin
            bOutPrev_q <= bOut_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            activeBit_q <= 1'b0;
        end else if (mode == DTC_CARRIER && tickA && eqA) begin
            activeBit_q <= carrierCtl_q[BIT_NEXT];
        end else if (regWrEn && regAddr == ADDR_CARRIER) begin
            activeBit_q <= regWrData[BIT_ACTIVE];
        end
    end

    always_comb begin
        if (mode == DTC_CARRIER) begin
            outLevel = activeBit_q &&
                       (carrierCtl_q[BIT_LEVEL_SEL] || bOut_q);
        end else begin
            outLevel = bOut_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timerOutputPin <= 1'b0;
        end else begin
            timerOutputPin <= modeB_q[BIT_OUT_ENABLE] && outLevel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt requests.

    logic matchAPrev_q;
    logic matchBPrev_q;
    logic irqACause;
    logic irqBCause;

    assign irqBCause = isCascade ? jointMatch : eqB;
    assign irqACause = eqA && !isCascade && (mode != DTC_PWM);

    always_ff @(posedge clk) begin
        if (srst) begin
            matchAPrev_q <= 1'b0;
            matchBPrev_q <= 1'b0;
        end else begin
            matchAPrev_q <= irqACause && enA;
            matchBPrev_q <= irqBCause && enB;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timerAMatchIrq <= 1'b0;
            timerBMatchIrq <= 1'b0;
        end else begin
            timerAMatchIrq <= irqACause && enA && !matchAPrev_q;
            timerBMatchIrq <= irqBCause && enB && !matchBPrev_q;
        end
    end

endmodule : dtc_top

// >>> inc/dtc_pkg.sv
// Package for the dual 8-bit timer with carrier and PWM output.
// Assumes an 8-bit register port with 16-bit addresses and one clock.
package dtc_pkg;

    localparam logic [15:0] ADDR_A_COUNT = 16'hFF50;
    localparam logic [15:0] ADDR_A_CMP = 16'hFF51;
    localparam logic [15:0] ADDR_A_MODE = 16'hFF52;
    localparam logic [15:0] ADDR_B_CMP = 16'hFF53;
    localparam logic [15:0] ADDR_B_COUNT = 16'hFF54;
    localparam logic [15:0] ADDR_B_HWCMP = 16'hFF55;
    localparam logic [15:0] ADDR_B_MODE = 16'hFF56;
    localparam logic [15:0] ADDR_CARRIER = 16'hFF57;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] MODE_A_MASK = 8'hBE;
    localparam logic [7:0] MODE_B_MASK = 8'hBF;
    localparam logic [7:0] CARRIER_MASK = 8'h07;

    localparam int BIT_ENABLE = 7;
    localparam int BIT_CLK_HI = 5;
    localparam int BIT_CLK_LO = 3;
    localparam int BIT_MODE_HI = 2;
    localparam int BIT_MODE_LO = 1;
    localparam int BIT_OUT_ENABLE = 0;
    localparam int BIT_ACTIVE = 0;
    localparam int BIT_NEXT = 1;
    localparam int BIT_LEVEL_SEL = 2;

    localparam logic [3:0] MODE_DISCRETE = 4'h0;
    localparam logic [3:0] MODE_CASCADE = 4'h5;
    localparam logic [3:0] MODE_CARRIER = 4'h3;
    localparam logic [3:0] MODE_PWM = 4'h2;

    localparam logic [2:0] A_CLK_DIV64 = 3'h0;
    localparam logic [2:0] A_CLK_DIV256 = 3'h1;
    localparam logic [2:0] A_CLK_BMATCH = 3'h2;
    localparam logic [2:0] A_CLK_BOUT = 3'h3;

    localparam logic [2:0] B_CLK_SYS = 3'h0;
    localparam logic [2:0] B_CLK_DIV4 = 3'h1;
    localparam logic [2:0] B_CLK_EXT = 3'h2;
    localparam logic [2:0] B_CLK_EXT2 = 3'h3;
    localparam logic [2:0] B_CLK_EXT4 = 3'h4;
    localparam logic [2:0] B_CLK_EXT8 = 3'h5;

    localparam int SYS_DIV_BITS = 8;
    localparam int EXT_DIV_BITS = 3;
    localparam int TAP_DIV4 = 2;
    localparam int TAP_DIV64 = 6;
    localparam int TAP_DIV256 = 8;

    typedef enum logic [2:0] {
        DTC_DISCRETE,
        DTC_CASCADE,
        DTC_CARRIER,
        DTC_PWM,
        DTC_PROHIBITED
    } dtc_mode_e;

endpackage : dtc_pkg

// >>> test/dtc_pin_partner.sv
// Far side: event source on the clock input pin, load on the output pin.
// Assumes the bench calls its tasks from its own thread.
`timescale 1ns/1ps
module dtc_pin_partner (
    input wire logic clk,
    input wire logic timerOutputPin,
    output logic eventClockInputPin
);
    initial eventClockInputPin = 1'b0;
    // input pin drive.
    // Sends n rising edges with random spacing.
    task automatic burst(input int n);
        repeat (n) begin
            @(negedge clk);
            eventClockInputPin = 1'b1;
            repeat ($urandom_range(2, 1)) @(negedge clk);
            eventClockInputPin = 1'b0;
            repeat ($urandom_range(3, 1)) @(negedge clk);
        end
    endtask : burst
    // output pin load.
    // Measures the next whole run of the output pin at level lvl.
    task automatic run(input logic lvl, output int n);
        int i;
        n = 0;
        for (i = 0; i < 500 && timerOutputPin === lvl; i++)
            @(negedge clk);
        for (i = 0; i < 500 && timerOutputPin !== lvl; i++)
            @(negedge clk);
        for (i = 0; i < 500 && timerOutputPin === lvl; i++) begin
            @(negedge clk);
            n++;
        end
    endtask : run
endmodule : dtc_pin_partner

// >>> test/dtc_properties.sv
// Port checker for the dual timer block.
// Assumes it is bound to dtc_top and sees its ports only.
`timescale 1ns/1ps
module dtc_properties
    import dtc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [15:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic eventClockInputPin,
    input wire logic timerOutputPin,
    input wire logic timerAMatchIrq,
    input wire logic timerBMatchIrq
);
    logic [7:0] modeAQ;
    logic [7:0] modeBQ;
    logic [7:0] cmpBQ;
    logic [9:0] ageQ;
    logic [8:0] gapQ;
    logic [3:0] modeSel;
    assign modeSel = {modeAQ[2:1], modeBQ[2:1]};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // Shadows of the written configuration.
    always_ff @(posedge clk) begin
        if (srst) begin
            modeAQ <= RST_BYTE;
            modeBQ <= RST_BYTE;
            cmpBQ <= RST_BYTE;
        end else if (regWrEn) begin
            if (regAddr == ADDR_A_MODE)
                modeAQ <= regWrData;
            if (regAddr == ADDR_B_MODE)
                modeBQ <= regWrData;
            if (regAddr == ADDR_B_CMP)
                cmpBQ <= regWrData;
        end
    end
    // Cycles since the last write and since the last B match.
    always_ff @(posedge clk) begin
        if (srst || regWrEn)
            ageQ <= '0;
        else if (ageQ != 10'h3FF)
            ageQ <= ageQ + 10'h001;
    end
    always_ff @(posedge clk) begin
        if (srst || timerBMatchIrq)
            gapQ <= 9'h001;
        else
            gapQ <= gapQ + 9'h001;
    end
////////////////////////////////////////////////////////////////////////////////
    sequence sVoidRead;
        regRdEn && (regAddr < ADDR_A_COUNT || regAddr >= ADDR_CARRIER);
    endsequence
    sequence sSteadyB;
        ageQ >= 10'h258 && modeSel == MODE_DISCRETE && modeBQ[7]
            && modeBQ[5:3] == B_CLK_SYS && cmpBQ != RST_BYTE;
    endsequence
    a_irq_a_once: assert property (timerAMatchIrq |=> !timerAMatchIrq)
        else $error("timer A request longer than a cycle");
    a_b_period: assert property (timerBMatchIrq ##0 sSteadyB
        |-> gapQ == {1'b0, cmpBQ} + 9'h001)
        else $error("timer B match period wrong");
    a_cascade_quiet: assert property (modeSel == MODE_CASCADE
        && $past(modeSel, 2) == MODE_CASCADE |-> !timerAMatchIrq)
        else $error("timer A request in cascade mode");
    a_read_hold: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data changed without a read");
    a_void_read: assert property (sVoidRead |=> regRdData == RST_BYTE)
        else $error("unmapped read not zero");
    a_mode_read: assert property (regRdEn && regAddr == ADDR_A_MODE
        |=> regRdData == (modeAQ & 8'hBE))
        else $error("timer A mode readback wrong");
    a_idle_zero: assert property (regRdEn && !modeAQ[7] && !modeBQ[7]
        && !$past(modeAQ[7]) && !$past(modeBQ[7])
        && (regAddr == ADDR_A_COUNT || regAddr == ADDR_B_COUNT)
        |=> regRdData == RST_BYTE)
        else $error("disabled counter not zero");
    a_reset_clear: assert property ($fell(srst) |-> !timerOutputPin
        && !timerAMatchIrq && !timerBMatchIrq && regRdData == RST_BYTE)
        else $error("outputs not clear after reset");
endmodule : dtc_properties

bind dtc_top dtc_properties chk (.clk, .srst, .regAddr, .regWrEn,
    .regWrData, .regRdEn, .regRdData, .eventClockInputPin,
    .timerOutputPin, .timerAMatchIrq, .timerBMatchIrq);

// >>> test/test_dtc_top.sv
// Bench for the dual timer: registers, modes, clock sources and pins.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
module test_dtc_top
    import dtc_pkg::*;
;
    logic clk;
    logic srst;
    logic [15:0] regAddr;
    logic regWrEn;
    logic [7:0] regWrData;
    logic regRdEn;
    logic [7:0] regRdData;
    logic eventClockInputPin;
    logic timerOutputPin;
    logic timerAMatchIrq;
    logic timerBMatchIrq;
    int nErrors;
    int totalChecks;
    int cyc;
    int n;
    int k;
    int base[4] = '{64, 256, 4, 8};
    logic [7:0] rd;
    logic [7:0] c;
    logic [15:0] g;
    dtc_top dut (.clk, .srst, .regAddr, .regWrEn, .regWrData, .regRdEn,
        .regRdData, .eventClockInputPin, .timerOutputPin, .timerAMatchIrq,
        .timerBMatchIrq);
    dtc_pin_partner pp (.clk, .timerOutputPin, .eventClockInputPin);
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Rule model: a counter that clears on match repeats every cmp + 1 steps.
    function automatic int periodOf(input int cmp, input int step);
        return step * (cmp + 1);
    endfunction : periodOf
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask : wr
    task automatic rdx(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        @(negedge clk);
        d = regRdData;
    endtask : rdx
    // Cycles between two successive match pulses of one timer.
    task automatic gap(input logic b, output logic [15:0] w);
        repeat (2) begin
            w = '0;
            do begin
                @(negedge clk);
                w++;
            end while ((b ? timerBMatchIrq : timerAMatchIrq) !== 1'b1
                && w < 16'h0FA0);
        end
    endtask : gap
    task automatic conclude();
        if (nErrors == 0 && totalChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            nErrors++;
            conclude();
        end
    end
    initial begin
        srst = 1'b1;
        regAddr = '0;
        regWrEn = 1'b0;
        regWrData = '0;
        regRdEn = 1'b0;
        void'($urandom(32'h7f6d));
        repeat (2) @(negedge clk);
        srst = 1'b0;
        for (k = 0; k < 9; k++) begin
            rdx(ADDR_A_COUNT + 16'(k), rd);
            check("reset read", rd, 8'h00);
        end
        wr(ADDR_A_MODE, 8'hFF);
        rdx(ADDR_A_MODE, rd);
        check("a mode", rd, 8'hBE);
        wr(ADDR_B_MODE, 8'h80);
        wr(ADDR_B_COUNT, 8'h5A);
        repeat (20) @(negedge clk);
        rdx(ADDR_B_COUNT, rd);
        check("held count", rd, 8'h00);
        wr(ADDR_A_MODE, 8'h00);
        repeat (2) begin
            c = 8'($urandom_range(200, 1));
            wr(ADDR_B_CMP, c);
            wr(ADDR_B_MODE, 8'h80);
            repeat (700) @(negedge clk);
            gap(1'b1, g);
            check("b period", g, 16'(periodOf(c, 1)));
        end
        wr(ADDR_B_CMP, 8'h03);
        wr(ADDR_A_CMP, 8'h02);
        for (k = 0; k < 4; k++) begin
            wr(ADDR_A_MODE, {2'b10, 3'(k), 3'b000});
            gap(1'b0, g);
            check("a period", g, 16'(periodOf(2, base[k])));
        end
        wr(ADDR_A_MODE, 8'h00);
        wr(ADDR_B_MODE, 8'h00);
        rdx(ADDR_A_COUNT, rd);
        check("a cleared", rd, 8'h00);
        wr(ADDR_B_CMP, 8'h03);
        wr(ADDR_B_MODE, 8'h88);
        gap(1'b1, g);
        check("b div4 period", g, 16'(periodOf(3, 4)));
        wr(ADDR_A_CMP, 8'h01);
        wr(ADDR_A_MODE, 8'h02);
        wr(ADDR_B_MODE, 8'h82);
        gap(1'b1, g);
        check("cascade period", g, 16'(periodOf(256 * 1 + 3, 1)));
        // pulse width; compare A left alone.
        wr(ADDR_A_MODE, 8'h00);
        wr(ADDR_B_CMP, 8'h05);
        wr(ADDR_B_HWCMP, 8'h02);
        wr(ADDR_B_MODE, 8'h85);
        pp.run(1'b1, n);
        check("pwm high", 16'(n), 16'h0003);
        pp.run(1'b0, n);
        check("pwm low", 16'(n), 16'h0006);
        wr(ADDR_B_MODE, 8'h87);
        wr(ADDR_A_CMP, 8'h01);
        wr(ADDR_CARRIER, 8'h06);
        wr(ADDR_A_MODE, 8'h80);
        check("carrier off", timerOutputPin, 1'b0);
        repeat (300) @(negedge clk);
        check("carrier on", timerOutputPin, 1'b1);
        // carrier passes while the active bit is set.
        wr(ADDR_CARRIER, 8'h03);
        pp.run(1'b1, n);
        check("carrier pulse", 16'(n), 16'h0003);
        for (k = 2; k < 6; k++) begin
            srst = 1'b1;
            @(negedge clk);
            srst = 1'b0;
            n = 8 * $urandom_range(12, 1);
            wr(ADDR_B_CMP, 8'hFF);
            wr(ADDR_B_MODE, {2'b10, 3'(k), 3'b000});
            pp.burst(n);
            repeat (4) @(negedge clk);
            rdx(ADDR_B_COUNT, rd);
            check("events", rd, 8'(n >> (k - 2)));
        end
        conclude();
    end
endmodule : test_dtc_top
